/* File: design/autoneg_np_consts.svh */
/*
 * Offsets, field positions and reset values of the auto-negotiation
 * next-page status bank, as `define macros.
 * Assumes a 32-bit AXI4-Lite slave; each register is one aligned word.
 */
`ifndef AUTONEG_NP_CONSTS_SVH
`define AUTONEG_NP_CONSTS_SVH

`define IDX_PARTNER_NP 8'h05
`define IDX_EXPANSION 8'h06
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define ADDR_W 8

`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_COMPLY_ACKNOWLEDGE_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10

`define EXP_PDF_BIT 4
`define EXP_LPNP_BIT 3
`define EXP_LNP_BIT 2
`define EXP_PAGE_BIT 1
`define EXP_LPAN_BIT 0

`define NP_RESET 16'h0000
`define IRQ_W 3
`define IRQ_PAGE 0
`define IRQ_FAULT 1
`define IRQ_ACK 2

`endif

/* File: design/autoneg_np_pkg.sv */
/*
 * Types shared by the next-page status bank.
 * Assumes the constants header is compiled alongside.
 */
package autoneg_np_pkg;

	// Word delivered by the negotiation engine for each received page
	typedef struct packed {
		logic more_pages_wanted;
		logic partner_ack;
		logic message_page_flag;
		logic comply_acknowledge;
		logic toggle;
		logic [10:0] code;
	} partner_page_t;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'h0,
		RESP_SLVERR = 2'h2
	} axi_resp_t;

endpackage : autoneg_np_pkg

/* File: design/autoneg_next_page_status.sv */
/*
 * Auto-negotiation next-page status bank: partner next-page word,
 * expansion status and a small interrupt pair, over AXI4-Lite.
 * Assumes the negotiation engine runs on clk_sys_i and pulses
 * page_valid_i for one cycle per received link code word.
 * The capability levels come from the same clock and are not synchronised.
 * Writes to the two status words are answered OKAY and dropped.
 * Limitation: only wstrb[0] is looked at, and only by the interrupt pair.
 */
`timescale 1ns/1ps
`include "autoneg_np_consts.svh"

module autoneg_next_page_status
	import autoneg_np_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [31:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [31:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic page_valid_i,
	input wire partner_page_t page_i,
	input wire logic parallel_detect_fault_i,
	input wire logic partner_next_page_capable_i,
	input wire logic partner_autoneg_capable_i,
	output logic irq_o
);

	// Stored next-page word and registered capability levels
	partner_page_t np_word;
	logic parallel_detect_fault;
	logic lp_np;
	logic lp_an;
	logic page_rx;
	logic pdf_q;
	logic fault_rise;

	// Write channel holding registers and decode
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [`ADDR_W-1:0] wr_idx;
	logic aw_in_range;
	logic wr_known;
	logic wr_to_status;
	logic wr_to_mask;

	// Read channel decode and next answer
	logic rd_go;
	logic [`ADDR_W-1:0] rd_idx;
	logic ar_in_range;
	logic exp_read;
	logic [15:0] exp_word;
	logic [31:0] next_rdata;
	logic next_rresp_err;

	// Interrupt bank
	logic [`IRQ_W-1:0] irq_status;
	logic [`IRQ_W-1:0] irq_mask;
	logic [`IRQ_W-1:0] irq_evt;
	logic [`IRQ_W-1:0] irq_clr;

	////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order

	// Ready drops while a channel is held or the answer waits: one write at a time
	assign awready_o = !aw_held && !bvalid_o;
	assign wready_o = !w_held && !bvalid_o;
	assign wr_go = aw_held && w_held && !bvalid_o;
	assign wr_idx = aw_addr[`ADDR_W+1:2];

	// Decode once; the response and the interrupt registers share it
	assign aw_in_range = aw_addr[31:`ADDR_W+2] == '0;
	assign wr_known = aw_in_range && (wr_idx == `IDX_PARTNER_NP ||
		wr_idx == `IDX_EXPANSION || wr_idx == `IDX_IRQ_STATUS ||
		wr_idx == `IDX_IRQ_MASK);
	assign wr_to_status = wr_go && aw_in_range && wr_idx == `IDX_IRQ_STATUS &&
		w_strb[0];
	assign wr_to_mask = wr_go && aw_in_range && wr_idx == `IDX_IRQ_MASK &&
		w_strb[0];

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held <= 1'b0;
		end else if (awvalid_i && awready_o) begin
			aw_held <= 1'b1;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_addr <= 32'h00000000;
		end else if (awvalid_i && awready_o) begin
			aw_addr <= awaddr_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_held <= 1'b0;
		end else if (wvalid_i && wready_o) begin
			w_held <= 1'b1;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_data <= 32'h00000000;
		end else if (wvalid_i && wready_o) begin
			w_data <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_strb <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			w_strb <= wstrb_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bvalid_o <= 1'b0;
		end else if (wr_go) begin
			bvalid_o <= 1'b1;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	// Unmapped addresses answer SLVERR; status registers accept and drop writes
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bresp_o <= RESP_OKAY;
		end else if (wr_go && wr_known) begin
			bresp_o <= RESP_OKAY;
		end else if (wr_go) begin
			bresp_o <= RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data

	// Ready stays low while an answer waits, so a read never overwrites one
	assign arready_o = !rvalid_o;
	assign rd_go = arvalid_i && arready_o;
	assign rd_idx = araddr_i[`ADDR_W+1:2];
	assign ar_in_range = araddr_i[31:`ADDR_W+2] == '0;
	assign exp_read = rd_go && ar_in_range && rd_idx == `IDX_EXPANSION;

	// Expansion word; upper bits stay zero whatever was written
	always_comb begin
		exp_word = 16'h0000;
		exp_word[`EXP_PDF_BIT] = parallel_detect_fault;
		exp_word[`EXP_LPNP_BIT] = lp_np;
		exp_word[`EXP_LNP_BIT] = 1'b1;
		exp_word[`EXP_PAGE_BIT] = page_rx;
		exp_word[`EXP_LPAN_BIT] = lp_an;
	end

	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp_err = 1'b0;
		if (!ar_in_range) begin
			next_rresp_err = 1'b1;
		end else begin
			unique case (rd_idx)
				`IDX_PARTNER_NP: begin
					next_rdata[15:0] = np_word;
				end
				`IDX_EXPANSION: begin
					next_rdata[15:0] = exp_word;
				end
				`IDX_IRQ_STATUS: begin
					next_rdata[`IRQ_W-1:0] = irq_status;
				end
				`IDX_IRQ_MASK: begin
					next_rdata[`IRQ_W-1:0] = irq_mask;
				end
				default: begin
					next_rresp_err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rvalid_o <= 1'b0;
		end else if (rd_go) begin
			rvalid_o <= 1'b1;
		end else if (rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 32'h00000000;
		end else if (rd_go) begin
			rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rresp_o <= RESP_OKAY;
		end else if (rd_go && next_rresp_err) begin
			rresp_o <= RESP_SLVERR;
		end else if (rd_go) begin
			rresp_o <= RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Partner next-page word, written only by the engine

	// Control bits as received; bus writes never reach here
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			np_word.more_pages_wanted <= 1'b0;
			np_word.partner_ack <= 1'b0;
			np_word.message_page_flag <= 1'b0;
			np_word.comply_acknowledge <= 1'b0;
			np_word.toggle <= 1'b0;
		end else if (page_valid_i) begin
			np_word.more_pages_wanted <= page_i.more_pages_wanted;
			np_word.partner_ack <= page_i.partner_ack;
			np_word.message_page_flag <= page_i.message_page_flag;
			np_word.comply_acknowledge <= page_i.comply_acknowledge;
			np_word.toggle <= page_i.toggle;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			np_word.code <= 11'h000;
		end else if (page_valid_i) begin
			np_word.code <= page_i.code;
		end
	end

	// Levels registered once for a clean read path
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			parallel_detect_fault <= 1'b0;
		end else begin
			parallel_detect_fault <= parallel_detect_fault_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lp_np <= 1'b0;
		end else begin
			lp_np <= partner_next_page_capable_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lp_an <= 1'b0;
		end else begin
			lp_an <= partner_autoneg_capable_i;
		end
	end

	// A page landing in the read cycle survives: set beats clear
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			page_rx <= 1'b0;
		end else if (page_valid_i) begin
			page_rx <= 1'b1;
		end else if (exp_read) begin
			page_rx <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write one to clear, mask enables

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pdf_q <= 1'b0;
		end else begin
			pdf_q <= parallel_detect_fault;
		end
	end

	// Fault interrupt on the rising edge only, so a standing fault fires once
	assign fault_rise = parallel_detect_fault && !pdf_q;
	assign irq_evt[`IRQ_PAGE] = page_valid_i;
	assign irq_evt[`IRQ_FAULT] = fault_rise;
	assign irq_evt[`IRQ_ACK] = page_valid_i && page_i.partner_ack;
	assign irq_clr = wr_to_status ? w_data[`IRQ_W-1:0] : '0;

	// One sticky bit per event; an event in the clearing cycle is kept
	for (genvar b = 0; b < `IRQ_W; b++) begin : g_irq_bit
		always_ff @(posedge clk_sys_i or negedge nrst_i) begin
			if (!nrst_i) begin
				irq_status[b] <= 1'b0;
			end else if (irq_evt[b]) begin
				irq_status[b] <= 1'b1;
			end else if (irq_clr[b]) begin
				irq_status[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_mask <= '0;
		end else if (wr_to_mask) begin
			irq_mask <= w_data[`IRQ_W-1:0];
		end
	end

	// Level output, high while any unmasked status bit is set
	assign irq_o = |(irq_status & irq_mask);

endmodule : autoneg_next_page_status

/* File: bench/autoneg_np_assertions.sv */
/* Checker for the next-page status bank.
 Sees only the top module's ports; bound at the foot. */
`timescale 1ns/1ps
module autoneg_np_checker
	import autoneg_np_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [31:0] araddr_i,
	input wire logic arvalid_i,
	input wire logic arready_o,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0] rresp_o,
	input wire logic rvalid_o,
	input wire logic rready_i,
	input wire logic bvalid_o,
	input wire logic bready_i,
	input wire logic page_valid_i,
	input wire partner_page_t page_i,
	input wire logic parallel_detect_fault_i,
	input wire logic partner_next_page_capable_i,
	input wire logic partner_autoneg_capable_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic ar;
	logic ar_exp;
	assign ar = arvalid_i && arready_o;
	assign ar_exp = ar && araddr_i == 32'h18;
	////////////////////////////////////////////////////////////
	AST_RD_LAT: assert property (ar |=> rvalid_o) else $error("read answer late");
	AST_R_HOLD: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped");
	AST_B_HOLD: assert property (bvalid_o && !bready_i |=> bvalid_o) else $error("bvalid dropped");
	AST_EXP_RSVD: assert property (ar_exp |=> rdata_o[15:5] == 11'h000)
		else $error("reserved bits set");
	AST_LOCAL_NP: assert property (ar_exp |=> rdata_o[2]) else $error("local bit low");
	// Levels are registered once, so the read shows them two edges back
	AST_LEVELS: assert property (ar_exp && $past(nrst_i) |=> rdata_o[4:3] ==
		$past({parallel_detect_fault_i, partner_next_page_capable_i}, 2)
		&& rdata_o[0] == $past(partner_autoneg_capable_i, 2)) else $error("level mismatch");
	AST_NP_WORD: assert property (page_valid_i ##1 ar && araddr_i == 32'h14
		|=> rdata_o[15:0] == $past(page_i, 2)) else $error("page word mismatch");
	AST_PAGE_RX: assert property (page_valid_i ##1 ar_exp |=> rdata_o[1])
		else $error("page flag missing");
	AST_UNMAPPED: assert property (ar && araddr_i == 32'h40 |=> rresp_o == 2'h2 && rdata_o == 0)
		else $error("unmapped read answered");
endmodule : autoneg_np_checker

bind autoneg_next_page_status autoneg_np_checker i_autoneg_np_checker (.*);

/* File: bench/autoneg_engine_model.sv */
/* Negotiation engine stand-in: delivers received pages and partner levels.
 Tasks are called right after a rising edge of clk_sys_i. */
`timescale 1ns/1ps
module autoneg_engine_model
	import autoneg_np_pkg::*;
(
	input wire logic clk_sys_i,
	output logic page_valid_o,
	output partner_page_t page_o,
	output logic [2:0] level_o
);
	initial begin
		page_valid_o = 1'b0;
		page_o = '0;
		level_o = 3'h0;
	end
	// Stale page is inverted so a late sample cannot pass by luck
	always @(posedge clk_sys_i) begin
		if (page_valid_o) begin
			page_valid_o <= 1'b0;
			page_o <= ~page_o;
		end
	end
	task automatic send(input partner_page_t p, input logic [2:0] lv);
		page_valid_o <= 1'b1;
		page_o <= p;
		level_o <= lv;
		@(posedge clk_sys_i);
	endtask : send
endmodule : autoneg_engine_model

/* File: bench/tb_autoneg_next_page_status.sv */
/* Self-checking bench for the next-page status bank.
 Drives AXI4-Lite and the engine model; expects a 250 MHz clock. */
`timescale 1ns/1ps
module tb_autoneg_next_page_status
	import autoneg_np_pkg::*;
;
	logic clk_sys_i = 0;
	logic nrst = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata_o, rd_d;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o, pv;
	logic [1:0] bresp_o, rresp_o, rd_r, wr_r;
	logic [2:0] lv;
	logic [15:0] s = 16'h0026;
	partner_page_t pg, p;
	int fail_count = 0, compares = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	autoneg_engine_model i_autoneg_engine_model (.clk_sys_i, .page_valid_o(pv), .page_o(pg),
		.level_o(lv));
	autoneg_next_page_status i_autoneg_next_page_status (.clk_sys_i, .nrst_i(nrst),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o, .wdata_i(wdata), .wstrb_i(4'hF),
		.wvalid_i(wvalid), .wready_o, .bresp_o, .bvalid_o, .bready_i(bready), .araddr_i(araddr),
		.arvalid_i(arvalid), .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i(rready),
		.page_valid_i(pv), .page_i(pg), .parallel_detect_fault_i(lv[2]),
		.partner_next_page_capable_i(lv[1]), .partner_autoneg_capable_i(lv[0]), .irq_o);
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [31:0] exp_x(input logic [2:0] l, input logic pr);
		return {27'h0, l[2:1], 1'b1, pr, l[0]};
	endfunction : exp_x
	task automatic report_and_stop();
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		logic ta = 0, tw = 0, tb = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !tb; n++) begin
			@(negedge clk_sys_i);
			ta = ta || awvalid && awready_o;
			tw = tw || wvalid && wready_o;
			tb = bvalid_o;
			wr_r = bresp_o;
			@(posedge clk_sys_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) begin
			fail_count++;
			report_and_stop();
		end
		@(posedge clk_sys_i);
	endtask : wr
	task automatic rd(input logic [31:0] a);
		int n;
		logic ta = 0, tr = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !tr; n++) begin
			@(negedge clk_sys_i);
			ta = ta || arvalid && arready_o;
			tr = rvalid_o;
			rd_d = rdata_o;
			rd_r = rresp_o;
			@(posedge clk_sys_i);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr) begin
			fail_count++;
			report_and_stop();
		end
		@(posedge clk_sys_i);
	endtask : rd
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys_i);
		nrst <= 1'b1;
		rd(32'h14);
		chk("np_reset", 0, rd_d);
		wr(32'h14, 32'hFFFFFFFF);
		chk("np_wr_resp", 0, wr_r);
		wr(32'h18, 32'hFFFFFFFF);
		rd(32'h14);
		chk("np_ro", 0, rd_d);
		rd(32'h18);
		chk("exp_ro", 32'h4, rd_d);
		for (int i = 0; i < 10; i++) begin
			s = lfsr(s);
			p = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : s;
			i_autoneg_engine_model.send(p, s[2:0]);
			rd(32'h14);
			chk("np_word", {16'h0, p}, rd_d);
			rd(32'h18);
			chk("exp_set", exp_x(s[2:0], 1'b1), rd_d);
			rd(32'h18);
			chk("exp_cleared", exp_x(s[2:0], 1'b0), rd_d);
		end
		i_autoneg_engine_model.send(16'h0800, 3'h5);
		rd(32'h18);
		chk("exp_direct", exp_x(3'h5, 1'b1), rd_d);
		rd(32'h40);
		chk("bad_rd", 32'h0, rd_d);
		chk("bad_rresp", 32'h2, 32'(rd_r));
		wr(32'h40, 32'h1);
		chk("bad_bresp", 32'h2, 32'(wr_r));
		wr(32'h84, 32'h1);
		i_autoneg_engine_model.send(16'h1234, 3'h0);
		rd(32'h80);
		chk("irq_status", 32'h1, rd_d & 32'h1);
		chk("irq_on", 32'h1, 32'(irq_o));
		wr(32'h80, 32'h7);
		@(negedge clk_sys_i);
		chk("irq_cleared", 32'h0, 32'(irq_o));
		wr(32'h84, 32'h0);
		i_autoneg_engine_model.send(16'h0001, 3'h0);
		repeat (2) @(negedge clk_sys_i);
		chk("irq_masked", 32'h0, 32'(irq_o));
		report_and_stop();
	end
endmodule : tb_autoneg_next_page_status
